// >>> verilog/irs_seq.sv
// infrared pattern sequencer: symbol and packet looping with led-off gaps
// assumes register requests come from logic on clk, and that
// software keeps gap values at 8 or above and symbol length at 1 or above
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.svh"

module irs_seq
    import irs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire irs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // interrupt clear from the device-wide interrupt logic
    input wire logic eot_clear,
    // beam output
    output irs_beam_t beam,
    // remote-control machine control
    output logic rc_run,
    output logic rc_restart,
    // status
    output logic eot_irq,
    output logic eot_mirror
);

    logic int_en_ff;
    logic [7:0] sym_repeat_ff;
    logic [7:0] sym_gap_ff;
    logic [7:0] pkt_repeat_ff;
    logic [7:0] pkt_gap_ff;
    logic [`IRS_BIT_PERIOD_W-1:0] bit_period_ff;
    logic [7:0] sym_len_ff;
    logic bar_start_ff;
    logic rc_start_ff;
    logic rc_restart_ff;
    logic eot_ff;
    logic [7:0] rdata_ff;
    irs_state_t state_ff;
    irs_state_t nxt_state;
    logic [10:0] cnt_ff;
    logic [7:0] sym_num_ff;
    logic [7:0] pkt_num_ff;
    logic bit_tick;
    logic busy;
    logic wr_start;
    logic [10:0] limit;
    logic phase_end;
    logic done;

    assign wr_start = reg_req.wr && (reg_req.addr == `IRS_ADDR_START);
    assign busy = (state_ff != IRS_IDLE);

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            int_en_ff <= 1'b0;
            sym_repeat_ff <= `IRS_RST_BYTE;
            sym_gap_ff <= `IRS_RST_BYTE;
            pkt_repeat_ff <= `IRS_RST_BYTE;
            pkt_gap_ff <= `IRS_RST_BYTE;
            bit_period_ff <= `IRS_RST_BIT_PERIOD;
            sym_len_ff <= `IRS_RST_BYTE;
        end
        else if (reg_req.wr)
        begin
            unique case (reg_req.addr)
                `IRS_ADDR_CONFIG: int_en_ff <= reg_req.wdata[`IRS_CFG_IEN_BIT];
                `IRS_ADDR_SYM_REPEAT: sym_repeat_ff <= reg_req.wdata;
                `IRS_ADDR_SYM_GAP: sym_gap_ff <= reg_req.wdata;
                `IRS_ADDR_PKT_REPEAT: pkt_repeat_ff <= reg_req.wdata;
                `IRS_ADDR_PKT_GAP: pkt_gap_ff <= reg_req.wdata;
                `IRS_ADDR_BIT_PERIOD: bit_period_ff <= reg_req.wdata[`IRS_BIT_PERIOD_W-1:0];
                `IRS_ADDR_SYM_LEN: sym_len_ff <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // start register
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            bar_start_ff <= 1'b0;
        else if (wr_start)
            bar_start_ff <= reg_req.wdata[`IRS_START_BAR_BIT];
        else if (done)
            bar_start_ff <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rc_start_ff <= 1'b0;
            rc_restart_ff <= 1'b0;
        end
        else
        begin
            if (wr_start)
                rc_start_ff <= reg_req.wdata[`IRS_START_RC_BIT];
            rc_restart_ff <= wr_start && reg_req.wdata[`IRS_START_RC_BIT];
        end
    end

    assign rc_run = rc_start_ff;
    assign rc_restart = rc_restart_ff;

    // ----------------------------------------
    // bit timing
    // ----------------------------------------
    irs_bit_timer irs_bit_timer_i (
        .clk(clk),
        .nrst(nrst),
        .run(busy),
        .bit_period(bit_period_ff),
        .bit_tick(bit_tick)
    );

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb
    begin
        unique case (state_ff)
            IRS_SYMBOL: limit = {sym_len_ff, 3'h7};
            IRS_SYM_GAP: limit = {2'h0, sym_gap_ff, 1'b0};
            IRS_PKT_GAP: limit = {2'h0, pkt_gap_ff, 1'b0};
            IRS_IDLE: limit = 11'h000;
        endcase
    end

    assign phase_end = bit_tick && (cnt_ff == limit);
    assign done = (state_ff == IRS_SYMBOL) && phase_end
        && (sym_num_ff == sym_repeat_ff) && (pkt_num_ff == pkt_repeat_ff);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            IRS_IDLE:
                if (wr_start && reg_req.wdata[`IRS_START_BAR_BIT])
                    nxt_state = IRS_SYMBOL;
            IRS_SYMBOL:
                if (done)
                    nxt_state = IRS_IDLE;
                else if (phase_end && sym_num_ff == sym_repeat_ff)
                    nxt_state = IRS_PKT_GAP;
                else if (phase_end)
                    nxt_state = IRS_SYM_GAP;
            IRS_SYM_GAP, IRS_PKT_GAP:
                if (phase_end)
                    nxt_state = IRS_SYMBOL;
        endcase
        if (wr_start && !reg_req.wdata[`IRS_START_BAR_BIT])
            nxt_state = IRS_IDLE;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_ff <= IRS_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_ff <= 11'h000;
        else if (nxt_state != state_ff || state_ff == IRS_IDLE)
            cnt_ff <= 11'h000;
        else if (bit_tick)
            cnt_ff <= cnt_ff + 11'h001;
    end

    // symbol and packet counters
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sym_num_ff <= 8'h00;
            pkt_num_ff <= 8'h00;
        end
        else if (state_ff == IRS_IDLE)
        begin
            sym_num_ff <= 8'h00;
            pkt_num_ff <= 8'h00;
        end
        else if (state_ff == IRS_SYMBOL && phase_end)
        begin
            if (sym_num_ff == sym_repeat_ff)
            begin
                sym_num_ff <= 8'h00;
                pkt_num_ff <= pkt_num_ff + 8'h01;
            end
            else
                sym_num_ff <= sym_num_ff + 8'h01;
        end
    end

    // ----------------------------------------
    // beam output
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            beam <= '0;
        else
        begin
            beam.led_on <= (nxt_state == IRS_SYMBOL);
            beam.byte_idx <= (nxt_state == state_ff && state_ff == IRS_SYMBOL)
                ? (bit_tick ? 8'((cnt_ff + 11'h001) >> 3) : cnt_ff[10:3]) : 8'h00;
            beam.bit_idx <= (nxt_state == state_ff && state_ff == IRS_SYMBOL)
                ? (bit_tick ? cnt_ff[2:0] + 3'h1 : cnt_ff[2:0]) : 3'h0;
        end
    end

    // ----------------------------------------
    // end-of-transmission flag
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            eot_ff <= 1'b0;
        else if (done && int_en_ff)
            eot_ff <= 1'b1;
        else if (eot_clear)
            eot_ff <= 1'b0;
    end

    assign eot_irq = eot_ff;
    assign eot_mirror = eot_ff;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata_ff <= 8'h00;
        else if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `IRS_ADDR_CONFIG: rdata_ff <= {2'h0, int_en_ff, 5'h00};
                `IRS_ADDR_SYM_REPEAT: rdata_ff <= sym_repeat_ff;
                `IRS_ADDR_SYM_GAP: rdata_ff <= sym_gap_ff;
                `IRS_ADDR_PKT_REPEAT: rdata_ff <= pkt_repeat_ff;
                `IRS_ADDR_PKT_GAP: rdata_ff <= pkt_gap_ff;
                `IRS_ADDR_BIT_PERIOD: rdata_ff <= {2'h0, bit_period_ff};
                `IRS_ADDR_SYM_LEN: rdata_ff <= sym_len_ff;
                `IRS_ADDR_STATUS: rdata_ff <= {6'h00, eot_ff, busy};
                `IRS_ADDR_START: rdata_ff <= {6'h00, rc_start_ff, bar_start_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata = rdata_ff;

endmodule
`default_nettype wire

// >>> verilog/irs_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz clock and byte-wide register access
//
// Contract
// - each packet sends the stored symbol symbol_repeat_count plus one times.
// - the led stays off for twice symbol_gap_time plus one bit times between symbols of a packet.
// - the whole packet is sent packet_repeat_count plus one times.
// - the led stays off for twice packet_gap_time plus one bit times between packets.
// - one bit time is the six-bit bit_period field plus one times a quarter microsecond; bits 7 and 6 are reserved.
// - a symbol holds symbol_byte_length plus one bytes.
// - status bit 0 is high exactly while a transmission is in progress.
// - with the interrupt enable set, finishing a block sets status bit 1 and raises the interrupt.
// - the end-of-transmission flag is mirrored into the main status register.
// - writing 1 to the barcode start bit begins a transmission and writing 0 stops it.
// - writing 1 to the remote-control start bit runs that machine from pattern address 0 and 0 stops it.
// - beam interrupts are produced only while the enable bit in the beam configuration register is set.
`ifndef IRS_REGS_SVH
`define IRS_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define IRS_ADDR_CONFIG 8'ha0
`define IRS_ADDR_SYM_REPEAT 8'ha2
`define IRS_ADDR_SYM_GAP 8'ha3
`define IRS_ADDR_PKT_REPEAT 8'ha4
`define IRS_ADDR_PKT_GAP 8'ha5
`define IRS_ADDR_BIT_PERIOD 8'ha6
`define IRS_ADDR_SYM_LEN 8'ha7
`define IRS_ADDR_STATUS 8'ha8
`define IRS_ADDR_START 8'ha9

// ----------------------------------------
// fields
// ----------------------------------------
`define IRS_CFG_IEN_BIT 5
`define IRS_START_BAR_BIT 0
`define IRS_START_RC_BIT 1
`define IRS_STAT_BUSY_BIT 0
`define IRS_STAT_EOT_BIT 1
`define IRS_BIT_PERIOD_W 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define IRS_RST_BYTE 8'h00
`define IRS_RST_BIT_PERIOD 6'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define IRS_CLK_PERIOD_NS 50
`define IRS_QUARTER_US_NS 250
`define IRS_QUARTER_CYC (`IRS_QUARTER_US_NS / `IRS_CLK_PERIOD_NS)
`define IRS_BITS_PER_BYTE 8

`endif

// >>> verilog/irs_pkg.sv
// types shared by the sequencer files
// assumes irs_regs.svh supplies the numeric constants
package irs_pkg;

    typedef enum logic [1:0] {
        IRS_IDLE,
        IRS_SYMBOL,
        IRS_SYM_GAP,
        IRS_PKT_GAP
    } irs_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irs_reg_req_t;

    typedef struct packed {
        logic led_on;
        logic [7:0] byte_idx;
        logic [2:0] bit_idx;
    } irs_beam_t;

endpackage

// >>> verilog/irs_bit_timer.sv
// bit-time enable generator
// assumes run is held high for the whole transmission
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.svh"

module irs_bit_timer
    import irs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic run,
    input wire logic [`IRS_BIT_PERIOD_W-1:0] bit_period,
    // one-cycle pulse per bit time
    output logic bit_tick
);

    localparam logic [2:0] QUARTER_LAST = 3'(`IRS_QUARTER_CYC - 1);

    logic [2:0] qcnt_ff;
    logic [`IRS_BIT_PERIOD_W-1:0] pcnt_ff;
    logic quarter_end;

    assign quarter_end = (qcnt_ff == QUARTER_LAST);

    // ----------------------------------------
    // quarter microsecond prescaler
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            qcnt_ff <= 3'h0;
        else if (!run || quarter_end)
            qcnt_ff <= 3'h0;
        else
            qcnt_ff <= qcnt_ff + 3'h1;
    end

    // ----------------------------------------
    // bit period counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pcnt_ff <= `IRS_RST_BIT_PERIOD;
        else if (!run)
            pcnt_ff <= `IRS_RST_BIT_PERIOD;
        else if (quarter_end)
            pcnt_ff <= (pcnt_ff >= bit_period) ? `IRS_RST_BIT_PERIOD : pcnt_ff + 6'h01;
    end

    assign bit_tick = run && quarter_end && (pcnt_ff >= bit_period);

endmodule
`default_nettype wire

// >>> bench/irs_seq_props.sv
// concurrent checks on the sequencer ports
// assumes bind onto irs_seq, single clock domain
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.svh"
module irs_seq_props
    import irs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register side
    input wire irs_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic eot_clear,
    // outputs
    input wire irs_beam_t beam,
    input wire logic rc_run,
    input wire logic rc_restart,
    input wire logic eot_irq,
    input wire logic eot_mirror
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic wr_go;
    assign wr_go = reg_req.wr && reg_req.addr == `IRS_ADDR_START;
    logic stop_seen_ff;
    // last start-register write stopped the beam
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            stop_seen_ff <= 1'b0;
        else if (wr_go)
            stop_seen_ff <= !reg_req.wdata[`IRS_START_BAR_BIT];
    end
    property p_bt_rsvd; reg_req.rd && reg_req.addr == `IRS_ADDR_BIT_PERIOD |=> reg_rdata[7:6] == 2'h0; endproperty
    a_bt_rsvd: assert property (p_bt_rsvd) else $error("bit period reserved bits set");
    property p_st_rsvd; reg_req.rd && reg_req.addr == `IRS_ADDR_STATUS |=> reg_rdata[7:2] == 6'h00; endproperty
    a_st_rsvd: assert property (p_st_rsvd) else $error("status reserved bits set");
    property p_rd_hold; !reg_req.rd |=> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_stop; wr_go && !reg_req.wdata[0] |-> ##2 !beam.led_on; endproperty
    a_stop: assert property (p_stop) else $error("led still on after stop");
    property p_sym_min; $rose(beam.led_on) |-> (beam.led_on || stop_seen_ff)[*8]; endproperty
    a_sym_min: assert property (p_sym_min) else $error("symbol too short");
    property p_sym_idx; $rose(beam.led_on) |-> beam.byte_idx == 8'h00 && beam.bit_idx == 3'h0; endproperty
    a_sym_idx: assert property (p_sym_idx) else $error("symbol not starting at byte 0");
    property p_eot_hold; eot_irq && !eot_clear |=> eot_irq; endproperty
    a_eot_hold: assert property (p_eot_hold) else $error("eot dropped without clear");
    property p_eot_copy; $rose(eot_irq) |-> ##[0:1] eot_mirror; endproperty
    a_eot_copy: assert property (p_eot_copy) else $error("eot not mirrored");
    property p_eot_end; $rose(eot_irq) |-> !beam.led_on; endproperty
    a_eot_end: assert property (p_eot_end) else $error("eot during symbol");
    property p_rc_go; wr_go && reg_req.wdata[1] |=> rc_restart && rc_run; endproperty
    a_rc_go: assert property (p_rc_go) else $error("remote start missing");
    property p_rc_run; wr_go |=> rc_run == $past(reg_req.wdata[1]); endproperty
    a_rc_run: assert property (p_rc_run) else $error("remote run wrong");
    c_eot: cover property ($rose(eot_irq));
    c_stop: cover property (wr_go && !reg_req.wdata[0] && beam.led_on);
    c_rc: cover property (rc_restart);
endmodule
`default_nettype wire

// >>> bench/irs_rx_model.sv
// remote receiver: measures led on and off run lengths
// assumes led_on sampled on clk, clr held one cycle
`timescale 1ns/100ps
`default_nettype none
module irs_rx_model
(
    // clock
    input wire logic clk,
    // optical input and clear
    input wire logic led_on,
    input wire logic clr
);
    int n_on;
    int run_len;
    int on_len [8];
    int off_len [8];
    logic led_q;
    always @(posedge clk)
    begin
        if (clr)
        begin
            n_on = 0;
            run_len = 0;
            led_q = led_on;
        end
        else if (led_on && !led_q)
        begin
            if (n_on > 0 && n_on < 9)
                off_len[n_on-1] = run_len;
            n_on++;
            run_len = 1;
        end
        else if (!led_on && led_q)
        begin
            if (n_on < 9)
                on_len[n_on-1] = run_len;
            run_len = 1;
        end
        else
            run_len++;
        led_q = led_on;
    end
endmodule
`default_nettype wire

// >>> bench/irs_seq_bench.sv
// self-checking bench for the pattern sequencer
// assumes irs_rx_model watches the led and irs_seq_props is bound
`timescale 1ns/100ps
`default_nettype none
`include "irs_regs.svh"
`define IRS_CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module irs_seq_bench
    import irs_pkg::*;
;
    logic clk, nrst, eot_clear, rx_clr, rc_run, rc_restart, eot_irq, eot_mirror;
    irs_reg_req_t req;
    irs_beam_t beam;
    logic [7:0] rdata;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    irs_seq irs_seq_i (.clk(clk), .nrst(nrst), .reg_req(req), .reg_rdata(rdata), .eot_clear(eot_clear),
        .beam(beam), .rc_run(rc_run), .rc_restart(rc_restart), .eot_irq(eot_irq), .eot_mirror(eot_mirror));
    irs_rx_model irs_rx_model_i (.clk(clk), .led_on(beam.led_on), .clr(rx_clr));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task run_check(input logic [7:0] bp, ln, sr, sg, pr, pg, input logic ien);
        logic [7:0] d;
        int t, n;
        t = (bp[5:0] + 1) * `IRS_QUARTER_CYC;
        n = (sr + 1) * (pr + 1);
        wr(`IRS_ADDR_CONFIG, {2'h0, ien, 5'h00});
        wr(`IRS_ADDR_BIT_PERIOD, bp);
        wr(`IRS_ADDR_SYM_LEN, ln);
        wr(`IRS_ADDR_SYM_REPEAT, sr);
        wr(`IRS_ADDR_SYM_GAP, sg);
        wr(`IRS_ADDR_PKT_REPEAT, pr);
        wr(`IRS_ADDR_PKT_GAP, pg);
        rx_clr <= 1'b1;
        @(posedge clk);
        rx_clr <= 1'b0;
        wr(`IRS_ADDR_START, 8'h01);
        rd(`IRS_ADDR_STATUS, d);
        `IRS_CHK(d, 8'h01);
        for (int i = 0; i < 20000 && !(irs_rx_model_i.n_on >= n && !beam.led_on); i++)
            @(posedge clk);
        #1;
        `IRS_CHK(irs_rx_model_i.n_on, n);
        for (int k = 0; k < n; k++)
        begin
            `IRS_CHK(irs_rx_model_i.on_len[k], (ln + 1) * `IRS_BITS_PER_BYTE * t);
            if (k < n - 1)
                `IRS_CHK(irs_rx_model_i.off_len[k], (2 * (((k + 1) % (sr + 1) == 0) ? pg : sg) + 1) * t);
        end
        rd(`IRS_ADDR_STATUS, d);
        `IRS_CHK(d, {6'h00, ien, 1'b0});
        `IRS_CHK(eot_mirror, ien);
        repeat (4) @(posedge clk);
        `IRS_CHK(eot_irq, ien);
        eot_clear <= 1'b1;
        @(posedge clk);
        eot_clear <= 1'b0;
        #1;
        `IRS_CHK(eot_irq, 1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        logic [7:0] d;
        for (int a = 8'ha2; a <= 8'ha8; a++)
        begin
            rd(a[7:0], d);
            `IRS_CHK(d, 8'h00);
            wr(a[7:0], 8'hc5 + a[7:0]);
            rd(a[7:0], d);
            `IRS_CHK(d, a == 8'ha8 ? 8'h00 : a == 8'ha6 ? 8'h2b : 8'hc5 + a[7:0]);
        end
        rd(8'h51, d);
        `IRS_CHK(d, 8'h00);
        $display("test regs done");
    endtask
    task t_loop;
        run_check(8'h00, 8'h01, 8'h01, 8'h08, 8'h01, 8'h09, 1'b1);
        $display("test loop done");
    endtask
    task t_slow;
        run_check(8'hc1, 8'h02, 8'h00, 8'h08, 8'h02, 8'h08, 1'b0);
        $display("test slow done");
    endtask
    task t_stop;
        logic [7:0] d;
        wr(`IRS_ADDR_CONFIG, 8'h20);
        wr(`IRS_ADDR_START, 8'h01);
        repeat (20) @(posedge clk);
        #1;
        // bit time is 10 cycles here, so two bits have gone by
        `IRS_CHK({beam.byte_idx, beam.bit_idx}, {8'h00, 3'h2});
        wr(`IRS_ADDR_START, 8'h00);
        rd(`IRS_ADDR_STATUS, d);
        `IRS_CHK(d, 8'h00);
        `IRS_CHK(beam.led_on, 1'b0);
        wr(`IRS_ADDR_START, 8'h01);
        rd(`IRS_ADDR_STATUS, d);
        `IRS_CHK(d, 8'h01);
        wr(`IRS_ADDR_START, 8'h00);
        $display("test stop done");
    endtask
    task t_rc;
        wr(`IRS_ADDR_START, 8'h02);
        `IRS_CHK({rc_run, rc_restart}, 2'h3);
        wr(`IRS_ADDR_START, 8'h00);
        `IRS_CHK(rc_run, 1'b0);
        $display("test remote done");
    endtask
    task results;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            $display("Error at %0t: timeout", $time);
            results();
        end
    end
    initial
    begin
        nrst = 1'b0;
        req = '0;
        eot_clear = 1'b0;
        rx_clr = 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_loop();
        t_slow();
        t_stop();
        t_rc();
        results();
    end
endmodule
bind irs_seq irs_seq_props irs_seq_props_i (.clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .eot_clear(eot_clear), .beam(beam), .rc_run(rc_run), .rc_restart(rc_restart), .eot_irq(eot_irq),
    .eot_mirror(eot_mirror));
`default_nettype wire
